// ===== rtl/sysref_divider_skew_window.sv
//
// Overview of operation
// R1: negative field sets early ignore window
// R2: negative codes give 0,1/2,1,3/2 clocks
// R3: positive field sets late ignore window
// R4: positive codes give 0,1/2,1,3/2 clocks
// R5: windows act only with auto adjust on
// R6: software keeps window sum below status
// R7: software disables reference before changing windows
// R8: edges inside window leave divider phase
// R9: zero window needs exact reference capture
// R10: applied phase is captured plus manual offset
// R11: status reports captured phase in half clocks
// R12: edges outside window realign the divider
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ps
`include "skew_consts.svh"
module sysref_divider_skew_window #(
   parameter logic [3:0] DIV_HALF = `DIV_HALF_DEF  // divider period, half clocks
) (
   // clock and reset
   input  wire logic        i_clk_sys,
   input  wire logic        i_reset,
   // ahb-lite slave
   input  wire logic        i_hsel,
   input  wire logic [31:0] i_haddr,
   input  wire logic [1:0]  i_htrans,
   input  wire logic        i_hwrite,
   input  wire logic [2:0]  i_hsize,
   input  wire logic [31:0] i_hwdata,
   input  wire logic        i_hready,
   output logic      [31:0] o_hrdata,
   output logic             o_hreadyout,
   output logic             o_hresp,
   // timing reference pin
   input  wire logic        i_sysref,
   // divider results
   output logic      [3:0]  o_div_phase,
   output logic             o_sysref_ignored,
   output logic             o_div_realigned
);
   // ***************************************************************
   // reference capture
   // ***************************************************************
   logic sysref_rise; // one-cycle rising edge, already filtered

   // filtering costs 3-4 cycles,
   // which only shifts the count
   // the pin is asynchronous to the device clock
   sysref_sync u_sync (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .i_pin     (i_sysref),
      .o_rise_ff (sysref_rise)
   );

   // ***************************************************************
   // divider tracking
   // ***************************************************************
   // fields out, status back
   skew_if sk ();

   skew_phase_tracker #(
      .DIV_HALF (DIV_HALF)
   ) u_tracker (
      .i_clk_sys (i_clk_sys),
      .i_reset   (i_reset),
      .sk        (sk)
   );

   // ***************************************************************
   // bus address phase
   // ***************************************************************
   logic       wr_pend_ff;  // write data phase follows
   logic [9:0] wr_idx_ff;   // register index of pending write
   // next values
   logic       nxt_wr_pend;
   logic [9:0] nxt_wr_idx;
   logic       take;        // address phase accepted this edge

   // only single whole-word transfers are expected; size is not decoded
   always_comb begin
      take        = i_hsel && i_htrans[1] && i_hready;
      nxt_wr_pend = 1'b0;
      nxt_wr_idx  = wr_idx_ff;
      // data follows next cycle
      if (take && i_hwrite) begin
         nxt_wr_pend = 1'b1;
         nxt_wr_idx  = i_haddr[11:2];
      end
   end

   // registers only
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         // no write pending
         wr_pend_ff <= 1'b0;
         wr_idx_ff  <= 10'h000;
      end else begin
         wr_pend_ff <= nxt_wr_pend;
         wr_idx_ff  <= nxt_wr_idx;
      end
   end

   // ***************************************************************
   // control registers
   // ***************************************************************
   logic             auto_en_ff;   // auto phase adjust enable
   skew_pkg::skew_t  neg_ff;       // early tolerance field
   skew_pkg::skew_t  pos_ff;       // late tolerance field
   skew_pkg::phase_t ofs_ff;       // manual phase offset
   // reset image of the fields
   localparam logic [7:0] RST_CTL = `RST_ALIGN_CTRL;
   // next values
   logic             nxt_auto_en;
   skew_pkg::skew_t  nxt_neg;
   skew_pkg::skew_t  nxt_pos;
   skew_pkg::phase_t nxt_ofs;

   // write data phase lands here; unmapped writes vanish
   always_comb begin
      nxt_auto_en = auto_en_ff;
      nxt_neg     = neg_ff;
      nxt_pos     = pos_ff;
      nxt_ofs     = ofs_ff;
      // data phase of a write
      if (wr_pend_ff) begin
         case (wr_idx_ff)
            `IDX_ALIGN_CTRL: begin
               // enable plus both windows
               nxt_auto_en = i_hwdata[`CTL_AUTO_BIT];
               // new windows take effect at once; keeping the
               // reference quiet meanwhile is up to software
               nxt_neg     = i_hwdata[`CTL_NEG_HI:`CTL_NEG_LO];  // see R1 see R7
               nxt_pos     = i_hwdata[`CTL_POS_HI:`CTL_POS_LO];  // see R3
            end
            // manual offset
            `IDX_PHASE_OFS: begin
               nxt_ofs = i_hwdata[`OFS_HI:0];
            end
            // status is read-only
            default: begin
               nxt_ofs = ofs_ff;
            end
         endcase
      end
   end

   // registers only
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         // start from reset image
         auto_en_ff <= RST_CTL[`CTL_AUTO_BIT];
         neg_ff     <= RST_CTL[`CTL_NEG_HI:`CTL_NEG_LO];
         pos_ff     <= RST_CTL[`CTL_POS_HI:`CTL_POS_LO];
         ofs_ff     <= `RST_PHASE_OFS;
      end else begin
         // take next values
         auto_en_ff <= nxt_auto_en;
         neg_ff     <= nxt_neg;
         pos_ff     <= nxt_pos;
         ofs_ff     <= nxt_ofs;
      end
   end

   // the tracker sees the programmed fields directly
   assign sk.auto_en     = auto_en_ff;
   assign sk.neg_skew    = neg_ff;
   assign sk.pos_skew    = pos_ff;
   assign sk.sysref_edge = sysref_rise;

   // ***************************************************************
   // read data
   // ***************************************************************
   // stands until next read
   logic [31:0] hrdata_ff;
   logic [31:0] nxt_hrdata;

   // read values come from the next-state so a write just before
   // a read of the same register is seen without a wait state
   always_comb begin
      nxt_hrdata = hrdata_ff;
      // only a taken read reloads
      if (take && !i_hwrite) begin
         case (i_haddr[11:2])
            // enable and windows
            `IDX_ALIGN_CTRL:
               nxt_hrdata = {24'h000000, nxt_auto_en, 3'h0, nxt_neg, nxt_pos};
            // manual offset
            `IDX_PHASE_OFS:
               nxt_hrdata = {28'h0000000, nxt_ofs};
            // captured phase
            `IDX_SYSREF_STAT:
               nxt_hrdata = {28'h0000000, sk.cap_phase};         // see R11
            // unmapped reads zero
            default:
               nxt_hrdata = 32'h00000000;
         endcase
      end
   end

   // registers only
   always_ff @(posedge i_clk_sys) begin
      // zero in reset
      if (i_reset)
         hrdata_ff <= 32'h00000000;
      else
         hrdata_ff <= nxt_hrdata;
   end

   // ***************************************************************
   // bus handshake and divider outputs
   // ***************************************************************
   logic             ready_ff;     // zero wait states after reset
   logic [3:0]       phase_ff;     // applied divider phase
   logic             ign_ff;
   logic             realn_ff;
   logic             resp_ff;      // always okay
   // next applied phase
   skew_pkg::phase_t nxt_phase;

   // applied phase: captured plus manual offset, or manual only
   always_comb begin
      if (auto_en_ff)
         nxt_phase = sk.cap_phase + ofs_ff;                      // see R10
      else
         // status unused when off
         nxt_phase = ofs_ff;                                     // see R5
   end

   // registers only
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         // not ready in reset
         ready_ff <= 1'b0;
         phase_ff <= 4'h0;
         ign_ff   <= 1'b0;
         realn_ff <= 1'b0;
         resp_ff  <= 1'b0;
      end else begin
         // ready from first edge
         ready_ff <= 1'b1;
         phase_ff <= nxt_phase;
         ign_ff   <= sk.ignored;
         realn_ff <= sk.realigned;
         resp_ff  <= 1'b0;
      end
   end

   // every output from a flop
   assign o_hrdata         = hrdata_ff;
   assign o_hreadyout      = ready_ff;
   assign o_hresp          = resp_ff;
   assign o_div_phase      = phase_ff;
   assign o_sysref_ignored = ign_ff;
   assign o_div_realigned  = realn_ff;

   // ***************************************************************
   // checks
   // bus and divider outputs
   // ***************************************************************
   a_ctrl_write_lands: assert property (                          // see R1
      @(posedge i_clk_sys) disable iff (i_reset)
      (wr_pend_ff && wr_idx_ff == `IDX_ALIGN_CTRL)
      |=> (neg_ff == $past(i_hwdata[3:2]) && pos_ff == $past(i_hwdata[1:0])
           && auto_en_ff == $past(i_hwdata[7])))
      else $error("control write not stored");

   a_phase_sum: assert property (                                 // see R10
      @(posedge i_clk_sys) disable iff (i_reset)
      auto_en_ff |=> (o_div_phase == $past(sk.cap_phase + ofs_ff)))
      else $error("applied phase is not captured plus offset");

   a_phase_manual: assert property (                              // see R5
      @(posedge i_clk_sys) disable iff (i_reset)
      !auto_en_ff |=> (o_div_phase == $past(ofs_ff)))
      else $error("manual phase disturbed while auto off");

   a_status_read: assert property (                               // see R11
      @(posedge i_clk_sys) disable iff (i_reset)
      (take && !i_hwrite && i_haddr[11:2] == `IDX_SYSREF_STAT)
      |=> (o_hrdata == {28'h0000000, $past(sk.cap_phase)}))
      else $error("status read does not show captured phase");

   a_ignored_follows: assert property (                           // see R8
      @(posedge i_clk_sys) disable iff (i_reset)
      sk.ignored |=> (o_sysref_ignored && !o_div_realigned))
      else $error("ignored edge not reported");

   a_realign_follows: assert property (                           // see R12
      @(posedge i_clk_sys) disable iff (i_reset)
      sk.realigned |=> (o_div_realigned && !o_sysref_ignored))
      else $error("realign not reported");

   a_status_quiet: assert property (                              // see R5
      @(posedge i_clk_sys) disable iff (i_reset)
      !(sk.sysref_edge && sk.auto_en) |=> $stable(sk.cap_phase))
      else $error("status moved without an accepted edge");

   a_ofs_write_lands: assert property (                           // see R10
      @(posedge i_clk_sys) disable iff (i_reset)
      (wr_pend_ff && wr_idx_ff == `IDX_PHASE_OFS)
      |=> (ofs_ff == $past(i_hwdata[`OFS_HI:0])))
      else $error("offset write not stored");
endmodule

// ===== rtl/skew_consts.svh
`ifndef SKEW_CONSTS_SVH
`define SKEW_CONSTS_SVH
// ***************************************************************
// register indices (byte address is four times the index)
// ***************************************************************
`define IDX_PHASE_OFS   10'h109
`define IDX_ALIGN_CTRL  10'h10a
`define IDX_SYSREF_STAT 10'h10b
// ***************************************************************
// field positions
// ***************************************************************
`define CTL_AUTO_BIT    7
`define CTL_NEG_HI      3
`define CTL_NEG_LO      2
`define CTL_POS_HI      1
`define CTL_POS_LO      0
`define OFS_HI          3
// ***************************************************************
// reset values
// ***************************************************************
`define RST_ALIGN_CTRL  8'h00
`define RST_PHASE_OFS   4'h0
`define RST_CAP_PHASE   4'h0
// ***************************************************************
// divider timing, in half device-clock units
// ***************************************************************
`define DIV_HALF_DEF    4'h8
`define PHASE_STEP      4'h2
`endif

// ===== rtl/skew_pkg.sv
package skew_pkg;
   // skew window field, half device-clock units
   typedef logic [1:0] skew_t;
   // divider phase, half device-clock units
   typedef logic [3:0] phase_t;
   // outcome of one captured reference edge
   typedef enum logic [1:0] {
      DEC_NONE    = 2'b00,
      DEC_IGNORE  = 2'b01,
      DEC_REALIGN = 2'b10,
      DEC_ALIGNED = 2'b11
   } decide_t;
endpackage

// ===== rtl/skew_if.sv
`timescale 1ns/1ps
interface skew_if;
   logic             auto_en;     // auto phase adjust enable
   skew_pkg::skew_t  neg_skew;    // early tolerance
   skew_pkg::skew_t  pos_skew;    // late tolerance
   logic             sysref_edge; // one-cycle synchronised edge
   skew_pkg::phase_t cap_phase;   // phase at last accepted capture
   skew_pkg::phase_t div_phase;   // running divider phase
   logic             ignored;     // edge fell inside window
   logic             realigned;   // divider was realigned
   modport ctrl (output auto_en, neg_skew, pos_skew, sysref_edge,
                 input  cap_phase, div_phase, ignored, realigned);
   modport tracker (input  auto_en, neg_skew, pos_skew, sysref_edge,
                    output cap_phase, div_phase, ignored, realigned);
endinterface

// ===== rtl/sysref_sync.sv
`timescale 1ns/1ps
module sysref_sync (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset,
   // raw pin and filtered result
   input  wire logic i_pin,
   output logic      o_rise_ff
);
   // ***************************************************************
   // three-stage capture, change accepted when stages two and three agree
   // ***************************************************************
   logic s1_ff;     // metastable stage, read only by s2
   logic s2_ff;     // second stage
   logic s3_ff;     // third stage
   logic level_ff;  // accepted level
   logic nxt_level;
   logic nxt_rise;

   // next accepted level and rising pulse
   always_comb begin
      nxt_level = level_ff;
      nxt_rise  = 1'b0;
      if (s2_ff == s3_ff) begin
         nxt_level = s3_ff;
         nxt_rise  = s3_ff & ~level_ff;
      end
   end

   // registers only
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         s1_ff     <= 1'b0;
         s2_ff     <= 1'b0;
         s3_ff     <= 1'b0;
         level_ff  <= 1'b0;
         o_rise_ff <= 1'b0;
      end else begin
         s1_ff     <= i_pin;
         s2_ff     <= s1_ff;
         s3_ff     <= s2_ff;
         level_ff  <= nxt_level;
         o_rise_ff <= nxt_rise;
      end
   end
endmodule

// ===== rtl/skew_phase_tracker.sv
`timescale 1ns/1ps
`include "skew_consts.svh"
module skew_phase_tracker #(
   parameter logic [3:0] DIV_HALF = `DIV_HALF_DEF  // divider period, half clocks
) (
   // clock and reset
   input  wire logic i_clk_sys,
   input  wire logic i_reset,
   // control and status toward the register side
   skew_if.tracker   sk
);
   // ***************************************************************
   // divider phase and window decision
   // ***************************************************************
   skew_pkg::phase_t  cnt_ff;       // local divider phase
   skew_pkg::phase_t  cap_ff;       // captured phase, status
   logic              ignored_ff;   // pulse: edge inside window
   logic              realigned_ff; // pulse: divider realigned
   skew_pkg::phase_t  nxt_cnt;
   skew_pkg::phase_t  nxt_cap;
   skew_pkg::phase_t  early;        // half clocks before the boundary
   skew_pkg::decide_t dec;
   logic [4:0]        sum;

   // one device clock is two half-clock units of the divider
   always_comb begin
      sum   = {1'b0, cnt_ff} + {1'b0, `PHASE_STEP};
      early = DIV_HALF - cnt_ff;
      dec   = skew_pkg::DEC_NONE;
      if (sk.sysref_edge && sk.auto_en) begin                    // see R5
         if (cnt_ff == 4'h0)
            dec = skew_pkg::DEC_ALIGNED;
         else if (cnt_ff <= {2'b00, sk.pos_skew})                // see R3 see R4
            dec = skew_pkg::DEC_IGNORE;
         else if (early <= {2'b00, sk.neg_skew})                 // see R1 see R2
            dec = skew_pkg::DEC_IGNORE;
         else
            dec = skew_pkg::DEC_REALIGN;                         // see R12
      end
      // free-running divider
      if (sum >= {1'b0, DIV_HALF})
         nxt_cnt = sum[3:0] - DIV_HALF;
      else
         nxt_cnt = sum[3:0];
      nxt_cap = cap_ff;
      case (dec)
         skew_pkg::DEC_REALIGN: begin
            // edge cycle becomes phase zero, so next is one step on
            nxt_cnt = `PHASE_STEP;                               // see R12
            nxt_cap = cnt_ff;                                    // see R10 see R11
         end
         skew_pkg::DEC_ALIGNED: begin
            nxt_cap = 4'h0;
         end
         default: begin
            // ignored edges leave phase and status alone
            nxt_cap = cap_ff;                                    // see R8
         end
      endcase
   end

   // registers only
   always_ff @(posedge i_clk_sys) begin
      if (i_reset) begin
         cnt_ff       <= 4'h0;
         cap_ff       <= `RST_CAP_PHASE;
         ignored_ff   <= 1'b0;
         realigned_ff <= 1'b0;
      end else begin
         cnt_ff       <= nxt_cnt;
         cap_ff       <= nxt_cap;
         ignored_ff   <= (dec == skew_pkg::DEC_IGNORE);
         realigned_ff <= (dec == skew_pkg::DEC_REALIGN);
      end
   end

   assign sk.cap_phase = cap_ff;
   assign sk.div_phase = cnt_ff;
   assign sk.ignored   = ignored_ff;
   assign sk.realigned = realigned_ff;

   // ***************************************************************
   // checks
   // ***************************************************************
   a_ignore_keeps_cap: assert property (                          // see R8
      @(posedge i_clk_sys) disable iff (i_reset)
      ignored_ff |-> ($stable(cap_ff) && !realigned_ff))
      else $error("ignored edge changed captured phase");
   a_late_window_hit: assert property (                           // see R3
      @(posedge i_clk_sys) disable iff (i_reset)
      (sk.sysref_edge && sk.auto_en && cnt_ff != 4'h0
       && cnt_ff <= {2'b00, sk.pos_skew}) |=> ignored_ff)
      else $error("late edge inside window not ignored");
   a_early_window_hit: assert property (                          // see R1
      @(posedge i_clk_sys) disable iff (i_reset)
      (sk.sysref_edge && sk.auto_en && cnt_ff != 4'h0
       && (DIV_HALF - cnt_ff) <= {2'b00, sk.neg_skew}) |=> ignored_ff)
      else $error("early edge inside window not ignored");
   a_disabled_quiet: assert property (                            // see R5
      @(posedge i_clk_sys) disable iff (i_reset)
      !sk.auto_en |=> (!ignored_ff && !realigned_ff && $stable(cap_ff)))
      else $error("skew logic acted while auto adjust off");
   a_outside_realigns: assert property (                          // see R12
      @(posedge i_clk_sys) disable iff (i_reset)
      (sk.sysref_edge && sk.auto_en && cnt_ff > {2'b00, sk.pos_skew}
       && (DIV_HALF - cnt_ff) > {2'b00, sk.neg_skew})
      |=> (realigned_ff && cap_ff == $past(cnt_ff) && cnt_ff == `PHASE_STEP))
      else $error("edge outside window did not realign");
endmodule

// ===== verif/sysref_source.sv
`timescale 1ns/1ps
// ***************************************************************
// reference clock source model
// ***************************************************************
module sysref_source (
   // device clock
   input  wire logic       i_clk_sys,
   // launch request from the bench
   input  wire logic       i_fire,
   input  wire logic [1:0] i_delay,
   // reference pin toward the device, push-pull
   output logic            o_sysref
);
   logic [2:0] wait_ff;  // cycles left before the rise
   logic [1:0] high_ff;  // cycles left at high level

   // idle low from time zero, never floating
   initial begin
      wait_ff  = 3'h0;
      high_ff  = 2'h0;
      o_sysref = 1'b0;
   end

   // rise lands on a device clock edge, so a zero window still captures cleanly
   always @(posedge i_clk_sys) begin
      if (i_fire) begin
         wait_ff <= {1'b0, i_delay} + 3'h1;
      end else if (wait_ff != 3'h0) begin
         wait_ff <= wait_ff - 3'h1;
         if (wait_ff == 3'h1) begin
            o_sysref <= 1'b1;
            high_ff  <= 2'h3;
         end
      end else if (high_ff != 2'h0) begin
         // three cycles high is enough for the three-flop filter
         high_ff <= high_ff - 2'h1;
         if (high_ff == 2'h1) begin
            o_sysref <= 1'b0;
         end
      end
   end
endmodule

// ===== verif/sysref_divider_skew_window_tb_top.sv
`timescale 1ns/1ps
`include "skew_consts.svh"
module sysref_divider_skew_window_tb_top;
   // ***************************************************************
   // signals
   // ***************************************************************
   localparam logic [3:0]  div_half  = 4'h8;                              // divider period
   localparam logic [31:0] addr_ofs  = {20'h0, `IDX_PHASE_OFS, 2'b00};    // phase offset
   localparam logic [31:0] addr_ctl  = {20'h0, `IDX_ALIGN_CTRL, 2'b00};   // control
   localparam logic [31:0] addr_stat = {20'h0, `IDX_SYSREF_STAT, 2'b00};  // status
   localparam logic [31:0] addr_none = 32'h0000_0430;                     // unmapped
   logic        clk_sys;     // device clock
   logic        reset;       // sync reset
   logic        hsel;        // bus select
   logic [31:0] haddr;       // bus address
   logic [1:0]  htrans;      // transfer type
   logic        hwrite;      // write strobe
   logic [2:0]  hsize;       // size, word only
   logic [31:0] hwdata;      // write data
   logic [31:0] hrdata;      // read data
   logic        hreadyout;   // slave ready, also bus ready
   logic        hresp;       // response
   logic        sysref;      // reference pin
   logic [3:0]  div_phase;   // applied divider phase
   logic        ignored;     // inside-window pulse
   logic        realigned;   // realign pulse
   logic        fire;        // launch request to source
   logic [1:0]  delay;       // launch delay
   int          err_count;   // mismatches
   int          comparisons; // checks made

   // ***************************************************************
   // instances
   // ***************************************************************
   sysref_divider_skew_window #(.DIV_HALF(div_half)) uut (
      .i_clk_sys        (clk_sys),
      .i_reset          (reset),
      .i_hsel           (hsel),
      .i_haddr          (haddr),
      .i_htrans         (htrans),
      .i_hwrite         (hwrite),
      .i_hsize          (hsize),
      .i_hwdata         (hwdata),
      .i_hready         (hreadyout),
      .o_hrdata         (hrdata),
      .o_hreadyout      (hreadyout),
      .o_hresp          (hresp),
      .i_sysref         (sysref),
      .o_div_phase      (div_phase),
      .o_sysref_ignored (ignored),
      .o_div_realigned  (realigned)
   );
   sysref_source source (
      .i_clk_sys (clk_sys),
      .i_fire    (fire),
      .i_delay   (delay),
      .o_sysref  (sysref)
   );

   // 25 ns device clock
   initial begin
      clk_sys = 1'b0;
      forever #12.5 clk_sys = ~clk_sys;
   end

   // ***************************************************************
   // tasks and functions
   // ***************************************************************
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      comparisons++;
      if (got !== exp) begin
         err_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic complete_run();
      if (err_count == 0 && comparisons > 0) begin
         $display("STATUS OK");
      end else begin
         $display("STATUS NOT OK");
      end
      $finish;
   endtask

   // waits for ready at a rising edge; the bench timeout ends a hang
   task automatic wait_ready();
      do begin
         @(posedge clk_sys);
      end while (hreadyout !== 1'b1);
   endtask

   // single word transfer; read data taken at the data-phase edge
   task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] d,
                      output logic [31:0] rd);
      @(posedge clk_sys);
      hsel   <= 1'b1;
      haddr  <= a;
      hwrite <= wr;
      htrans <= 2'b10;
      wait_ready();
      htrans <= 2'b00;
      hwdata <= d;
      wait_ready();
      rd = hrdata;
      check({31'h0, hresp}, 32'h0);
   endtask

   // edge outside both windows and off phase zero must realign
   function automatic logic outside(input logic [3:0] p, input logic [1:0] neg,
                                    input logic [1:0] pos);
      return (p != 4'h0) && (p > {2'b00, pos}) && ((div_half - p) > {2'b00, neg});
   endfunction

   // launch one reference edge and collect the pulses that follow
   task automatic fire_edge(input logic [1:0] dly, output logic ign, output logic rea);
      @(posedge clk_sys);
      fire  <= 1'b1;
      delay <= dly;
      @(posedge clk_sys);
      fire <= 1'b0;
      ign = 1'b0;
      rea = 1'b0;
      repeat (16) begin
         @(posedge clk_sys);
         ign = ign | (ignored === 1'b1);
         rea = rea | (realigned === 1'b1);
      end
   endtask

   // ***************************************************************
   // main sequence
   // ***************************************************************
   initial begin
      logic [31:0] rd;
      logic [31:0] wd;
      logic [3:0]  ofs;
      logic [3:0]  last;
      logic        ign;
      logic        rea;
      err_count   = 0;
      comparisons = 0;
      reset  = 1'b1;
      hsel   = 1'b0;
      haddr  = 32'h0;
      htrans = 2'b00;
      hwrite = 1'b0;
      hsize  = 3'h2;
      hwdata = 32'h0;
      fire   = 1'b0;
      delay  = 2'h0;
      void'($urandom(12));
      repeat (6) @(posedge clk_sys);
      reset <= 1'b0;
      repeat (2) @(posedge clk_sys);
      // reset values and unmapped place
      bus(1'b0, addr_ofs, 32'h0, rd);
      check(rd, 32'h0);
      bus(1'b0, addr_ctl, 32'h0, rd);
      check(rd, 32'h0);
      bus(1'b0, addr_stat, 32'h0, rd);
      check(rd, 32'h0);
      bus(1'b1, addr_none, $urandom, rd);
      bus(1'b0, addr_none, 32'h0, rd);
      check(rd, 32'h0);
      // read/write fields, reserved bits read zero, status read-only
      repeat (4) begin
         wd = $urandom;
         bus(1'b1, addr_ctl, wd, rd);
         bus(1'b0, addr_ctl, 32'h0, rd);
         check(rd, wd & 32'h8f);
         bus(1'b1, addr_ofs, wd, rd);
         bus(1'b0, addr_ofs, 32'h0, rd);
         check(rd, wd & 32'hf);
         bus(1'b1, addr_stat, wd, rd);
         bus(1'b0, addr_stat, 32'h0, rd);
         check(rd, 32'h0);
      end
      // auto adjust off: edges leave the divider alone
      ofs = 4'($urandom);
      bus(1'b1, addr_ctl, 32'h0f, rd);
      bus(1'b1, addr_ofs, {28'h0, ofs}, rd);
      repeat (4) begin
         fire_edge(2'($urandom), ign, rea);
         check({30'h0, ign, rea}, 32'h0);
         check({28'h0, div_phase}, {28'h0, ofs});
      end
      // every window code pair with auto adjust on
      last = 4'h0;
      for (int w = 0; w < 16; w++) begin
         ofs = 4'($urandom);
         // reference pin is idle while windows change
         bus(1'b1, addr_ctl, 32'h80 | w, rd);
         bus(1'b1, addr_ofs, {28'h0, ofs}, rd);
         repeat (6) begin
            fire_edge(2'($urandom), ign, rea);
            check({31'h0, ign & rea}, 32'h0);
            bus(1'b0, addr_stat, 32'h0, rd);
            if (rea) begin
               check({31'h0, outside(rd[3:0], w[3:2], w[1:0])}, 32'h1);
               check(rd & 32'hfffffff1, 32'h0);
               last = rd[3:0];
               check({28'h0, div_phase}, {28'h0, last + ofs});
            end else if (ign) begin
               check({31'h0, w == 0}, 32'h0);
               check(rd, {28'h0, last});
            end else begin
               check(rd, 32'h0);
               last = 4'h0;
            end
         end
      end
      complete_run();
   end

   // hang guard, well beyond the expected run length
   initial begin
      repeat (30000) @(posedge clk_sys);
      err_count++;
      complete_run();
   end
endmodule
